// >>> can_transceiver_mode_control_bench.sv
`timescale 1ns/1ps
module can_transceiver_mode_control_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ctmc_pkg::ctmc_wb_req_s wb_r = '0;
  ctmc_pkg::ctmc_wb_rsp_s wb_s;
  ctmc_pkg::ctmc_chip_e chip = ctmc_pkg::CHIP_NORMAL;
  ctmc_pkg::ctmc_chip_e cm [4];
  ctmc_pkg::ctmc_trx_e trx;
  logic v33 = 1'b0, auv = 1'b0, aov = 1'b0, suv = 1'b0, buv = 1'b0;
  logic txw = 1'b1, nd = 1'b0, wgo = 1'b0;
  logic [3:0] mb = 4'h0;
  logic [7:0] ph = 8'h3c;
  logic tx, bus, rx, bdo, auxon, pnp, mrr, mwo;
  logic [1:0] bias;
  logic [7:0] q, d;
  int n_fail = 0, comparisons = 0, n_mwo = 0, k, seed = 32'h7d59;
  // clock and wake pulse counter
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (mwo === 1'b1) n_mwo <= n_mwo + 1;
  ctmc_top #(.SILENCE_CYC(64), .WAKE_TO_CYC(400)) ctmc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_r), .wb_o(wb_s), .chip_mode_i(chip),
    .variant_3v3_i(v33), .main_below_i(mb), .aux_uv_i(auv), .aux_ov_i(aov),
    .trx_supply_uv_i(suv), .bat_uv_i(buv), .tx_i(tx), .bus_dom_i(bus), .rx_o(rx),
    .bus_dom_o(bdo), .bias_o(bias), .trx_mode_o(trx), .aux_on_o(auxon),
    .pnp_low_thr_o(pnp), .main_reset_req_o(mrr), .main_wake_on_o(mwo));
  ctmc_can_peer ctmc_can_peer_i (.clk_i(clk_i), .rst_i(rst_i), .dev_dom_i(bdo),
    .tx_want_i(txw), .node_dom_i(nd), .wup_go_i(wgo), .phase_i(ph), .tx_o(tx),
    .bus_dom_o(bus));
  // comparison and closing report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_r <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {a, 2'b00}, sel: 4'hf,
      dat: {24'h00_0000, v}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_s.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      complete_run();
    end else begin
      q = wb_s.dat[7:0];
      wb_r.cyc <= 1'b0;
      wb_r.stb <= 1'b0;
    end
  endtask
  // expected aux enable from config code and chip mode
  function automatic logic f_aux(input logic [1:0] c, input ctmc_pkg::ctmc_chip_e m);
    return c[1] ? (m inside {ctmc_pkg::CHIP_NORMAL, ctmc_pkg::CHIP_STANDBY,
      ctmc_pkg::CHIP_RESET} || (c[0] && m == ctmc_pkg::CHIP_SLEEP))
      : (c[0] && m == ctmc_pkg::CHIP_NORMAL);
  endfunction
  function automatic logic [1:0] f_bias(input ctmc_pkg::ctmc_trx_e e);
    if (e == ctmc_pkg::TRX_OFF) return ctmc_pkg::BIAS_FLOAT;
    else return (e == ctmc_pkg::TRX_OFFLINE) ? ctmc_pkg::BIAS_GND : ctmc_pkg::BIAS_MID;
  endfunction
  // set chip mode and mode field, then compare state and bias
  task automatic md(input ctmc_pkg::ctmc_chip_e c, input logic [1:0] f,
      input ctmc_pkg::ctmc_trx_e e);
    chip <= c;
    wb(1'b1, ctmc_pkg::IDX_CAN_CTRL, {6'h00, f});
    wt(4);
    chk(8'(trx), 8'(e));
    chk({6'h00, bias}, {6'h00, f_bias(e)});
  endtask
  // quiet bus, arm, send one pattern, read the flag
  task automatic wup(input logic en, input logic [7:0] cc, input logic [7:0] exp);
    wt(70);
    wb(1'b1, ctmc_pkg::IDX_WAKE_CTRL, {7'h00, en});
    wb(1'b1, ctmc_pkg::IDX_CAN_CTRL, cc);
    wgo <= 1'b1;
    wt(1);
    wgo <= 1'b0;
    wt(200);
    wb(1'b0, ctmc_pkg::IDX_WAKE_STAT, 8'h00);
    chk(q, exp);
  endtask
  // main sequence
  initial begin
    cm = '{ctmc_pkg::CHIP_NORMAL, ctmc_pkg::CHIP_STANDBY, ctmc_pkg::CHIP_RESET,
      ctmc_pkg::CHIP_SLEEP};
    wt(12);
    rst_i <= 1'b0;
    wt(2);
    wb(1'b0, ctmc_pkg::IDX_REG_CTRL, 8'h00);
    chk(q, ctmc_pkg::REGC_RST);
    wb(1'b0, ctmc_pkg::IDX_SUPPLY_STAT, 8'h00);
    chk(q, 8'h06);
    wb(1'b1, 8'h05, 8'hff);
    wb(1'b0, 8'h05, 8'h00);
    chk(q, 8'h00);
    $display("reset and unmapped done");
    // random control values, both variants, every threshold code
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed)) & 8'h4c;
      d[1:0] = i[2:1];
      v33 <= i[0];
      mb <= 4'($random(seed));
      wb(1'b1, ctmc_pkg::IDX_REG_CTRL, d);
      wb(1'b0, ctmc_pkg::IDX_REG_CTRL, 8'h00);
      if (i[0]) d[1:0] = 2'h0;
      chk(q, d);
      wt(2);
      chk({7'h00, pnp}, {7'h00, d[6]});
      chk({7'h00, mrr}, {7'h00, mb[d[1:0]]});
    end
    v33 <= 1'b0;
    mb <= 4'h0;
    // aux config against chip modes, aux status follows
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, ctmc_pkg::IDX_REG_CTRL, 8'(c << 2));
      for (int m = 0; m < 4; m++) begin
        chip <= cm[m];
        wt(3);
        chk({7'h00, auxon}, {7'h00, f_aux(2'(c), cm[m])});
        wb(1'b0, ctmc_pkg::IDX_SUPPLY_STAT, 8'h00);
        chk(q, f_aux(2'(c), cm[m]) ? 8'h00 : 8'h06);
      end
    end
    chip <= ctmc_pkg::CHIP_NORMAL;
    wb(1'b1, ctmc_pkg::IDX_REG_CTRL, 8'h04);
    auv <= 1'b1;
    mb <= 4'h1;
    wb(1'b0, ctmc_pkg::IDX_SUPPLY_STAT, 8'h00);
    chk(q, 8'h03);
    auv <= 1'b0;
    aov <= 1'b1;
    mb <= 4'h0;
    wb(1'b0, ctmc_pkg::IDX_SUPPLY_STAT, 8'h00);
    chk(q, 8'h04);
    aov <= 1'b0;
    $display("regulator registers done");
    // mode field in Normal
    md(ctmc_pkg::CHIP_NORMAL, 2'h0, ctmc_pkg::TRX_OFFLINE);
    md(ctmc_pkg::CHIP_NORMAL, 2'h1, ctmc_pkg::TRX_ACTIVE);
    wb(1'b0, ctmc_pkg::IDX_TRX_STAT, 8'h00);
    chk(q & 8'h80, 8'h80);
    md(ctmc_pkg::CHIP_NORMAL, 2'h2, ctmc_pkg::TRX_ACTIVE);
    md(ctmc_pkg::CHIP_NORMAL, 2'h3, ctmc_pkg::TRX_LISTEN);
    wb(1'b0, ctmc_pkg::IDX_TRX_STAT, 8'h00);
    chk(q & 8'h80, 8'h00);
    suv <= 1'b1;
    md(ctmc_pkg::CHIP_NORMAL, 2'h1, ctmc_pkg::TRX_OFFLINE);
    wb(1'b0, ctmc_pkg::IDX_TRX_STAT, 8'h00);
    chk(q & 8'h02, 8'h02);
    md(ctmc_pkg::CHIP_NORMAL, 2'h2, ctmc_pkg::TRX_ACTIVE);
    suv <= 1'b0;
    wb(1'b1, ctmc_pkg::IDX_REG_CTRL, 8'h05);
    mb <= 4'h3;
    md(ctmc_pkg::CHIP_NORMAL, 2'h2, ctmc_pkg::TRX_OFFLINE);
    mb <= 4'h1;
    md(ctmc_pkg::CHIP_NORMAL, 2'h2, ctmc_pkg::TRX_LISTEN);
    md(ctmc_pkg::CHIP_NORMAL, 2'h1, ctmc_pkg::TRX_LISTEN);
    mb <= 4'h0;
    $display("mode selection done");
    // held transmit line, then traffic both ways
    txw <= 1'b0;
    md(ctmc_pkg::CHIP_NORMAL, 2'h0, ctmc_pkg::TRX_OFFLINE);
    md(ctmc_pkg::CHIP_NORMAL, 2'h1, ctmc_pkg::TRX_LISTEN);
    chk({7'h00, bdo}, 8'h00);
    txw <= 1'b1;
    wt(3);
    chk(8'(trx), 8'(ctmc_pkg::TRX_ACTIVE));
    for (int i = 0; i < 16; i++) begin
      txw <= 1'($random(seed));
      nd <= 1'($random(seed));
      wt(3);
      chk({7'h00, bdo}, {7'h00, ~txw});
      chk({7'h00, rx}, {7'h00, ~(~txw | nd)});
    end
    md(ctmc_pkg::CHIP_NORMAL, 2'h3, ctmc_pkg::TRX_LISTEN);
    txw <= 1'b0;
    nd <= 1'b1;
    wt(3);
    chk({6'h00, bdo, rx}, 8'h00);
    txw <= 1'b1;
    nd <= 1'b0;
    $display("transfer done");
    // bus silence in Standby
    md(ctmc_pkg::CHIP_STANDBY, 2'h3, ctmc_pkg::TRX_OFFLINE_BIAS);
    wt(70);
    chk(8'(trx), 8'(ctmc_pkg::TRX_OFFLINE));
    wb(1'b0, ctmc_pkg::IDX_TRX_STAT, 8'h00);
    chk(q & 8'h08, 8'h08);
    nd <= 1'b1;
    wt(1);
    nd <= 1'b0;
    wt(50);
    chk(8'(trx), 8'(ctmc_pkg::TRX_OFFLINE_BIAS));
    wt(20);
    chk(8'(trx), 8'(ctmc_pkg::TRX_OFFLINE));
    $display("silence done");
    // undervoltage and chip Off
    buv <= 1'b1;
    md(ctmc_pkg::CHIP_NORMAL, 2'h1, ctmc_pkg::TRX_OFF);
    buv <= 1'b0;
    md(ctmc_pkg::CHIP_OFF, 2'h1, ctmc_pkg::TRX_OFF);
    md(ctmc_pkg::CHIP_OVERTEMP, 2'h1, ctmc_pkg::TRX_OFF);
    $display("off mode done");
    // wake patterns in Standby and Sleep
    chip <= ctmc_pkg::CHIP_STANDBY;
    wup(1'b0, 8'h00, 8'h00);
    wup(1'b1, 8'h30, 8'h00);
    wup(1'b1, 8'h10, 8'h01);
    chk({7'h00, rx}, 8'h00);
    wb(1'b1, ctmc_pkg::IDX_WAKE_STAT, 8'h01);
    wt(2);
    chk({7'h00, rx}, 8'h01);
    chip <= ctmc_pkg::CHIP_SLEEP;
    k = n_mwo;
    wup(1'b1, 8'h20, 8'h01);
    chk(8'(n_mwo - k), 8'h01);
    $display("wake done");
    complete_run();
  end
endmodule // can_transceiver_mode_control_bench

// >>> ctmc_can_peer.sv
`timescale 1ns/1ps
// far side: controller transmit line plus a bus shared with one other node
module ctmc_can_peer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_dom_i,
  input wire logic tx_want_i,
  input wire logic node_dom_i,
  input wire logic wup_go_i,
  input wire logic [7:0] phase_i,
  output logic tx_o,
  output logic bus_dom_o
);
  logic [9:0] cnt_r;
  logic [9:0] ph;
  logic wdom;
  // wake pattern timer, three equal phases counted down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 10'h000;
    end else if (wup_go_i) begin
      cnt_r <= 10'(3 * ph);
    end else if (cnt_r != 10'h000) begin
      cnt_r <= cnt_r - 10'h001;
    end
  end
  // dominant, recessive, dominant, one phase each
  assign ph = {2'h0, phase_i};
  assign wdom = (cnt_r > 10'(2 * ph)) || (cnt_r != 10'h000 && cnt_r <= ph);
  // wired bus: any dominant driver wins, released bus reads recessive
  assign bus_dom_o = dev_dom_i | node_dom_i | wdom;
  assign tx_o = tx_want_i; // idle controller holds recessive
endmodule // ctmc_can_peer

// >>> ctmc_pkg.sv
package ctmc_pkg;
  // timing base and derived cycle counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int SILENCE_TIMEOUT_US = 1000;
  localparam int SILENCE_CYC = (SILENCE_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_TO_US = 1000;
  localparam int WAKE_TO_CYC = (WAKE_TO_US * 1000) / CLK_PERIOD_NS;
  localparam int WAKE_DOM_MIN_NS = 500;
  localparam int WAKE_REC_MIN_NS = 500;
  localparam int WAKE_DOM_CYC = (WAKE_DOM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_REC_CYC = (WAKE_REC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_REG_CTRL = 8'h10;
  localparam logic [7:0] IDX_SUPPLY_STAT = 8'h1b;
  localparam logic [7:0] IDX_CAN_CTRL = 8'h20;
  localparam logic [7:0] IDX_TRX_STAT = 8'h22;
  localparam logic [7:0] IDX_WAKE_CTRL = 8'h30;
  localparam logic [7:0] IDX_WAKE_STAT = 8'h31;
  // field positions
  localparam int REGC_PNP_BIT = 6;
  localparam int REGC_AUX_LSB = 2;
  localparam int REGC_THR_LSB = 0;
  localparam int SUP_AUX_LSB = 1;
  localparam int SUP_MAIN_BIT = 0;
  localparam int CANC_FD_BIT = 6;
  localparam int CANC_CFG_BIT = 5;
  localparam int CANC_SEL_BIT = 4;
  localparam int CANC_MODE_LSB = 0;
  localparam int TRXS_ACTIVE_BIT = 7;
  localparam int TRXS_SILENCE_BIT = 3;
  localparam int TRXS_SUPPLY_BIT = 1;
  localparam int WAKE_EN_BIT = 0;
  localparam int WAKE_FLAG_BIT = 0;
  // reset values
  localparam logic [7:0] REGC_RST = 8'h00;
  localparam logic [7:0] CANC_RST = 8'h00;
  localparam logic WAKEC_RST = 1'b0;
  // field codes
  localparam logic [1:0] THR_90 = 2'h0;
  localparam logic [1:0] AUXC_OFF = 2'h0;
  localparam logic [1:0] AUXC_NORMAL = 2'h1;
  localparam logic [1:0] AUXC_AWAKE = 2'h2;
  localparam logic [1:0] AUX_OK = 2'h0;
  localparam logic [1:0] AUX_UV = 2'h1;
  localparam logic [1:0] AUX_OV = 2'h2;
  localparam logic [1:0] AUX_OFF = 2'h3;
  localparam logic [1:0] MODE_OFFLINE = 2'h0;
  localparam logic [1:0] MODE_ACT_UV = 2'h1;
  localparam logic [1:0] MODE_LISTEN = 2'h3;
  localparam logic [1:0] BIAS_FLOAT = 2'h0;
  localparam logic [1:0] BIAS_GND = 2'h1;
  localparam logic [1:0] BIAS_MID = 2'h2;
  typedef enum logic [2:0] {
    CHIP_OFF = 3'b000, CHIP_OVERTEMP = 3'b001, CHIP_RESET = 3'b010,
    CHIP_STANDBY = 3'b011, CHIP_SLEEP = 3'b100, CHIP_NORMAL = 3'b111
  } ctmc_chip_e;
  typedef enum logic [2:0] {
    TRX_OFF = 3'b000, TRX_OFFLINE = 3'b001, TRX_OFFLINE_BIAS = 3'b010,
    TRX_LISTEN = 3'b011, TRX_ACTIVE = 3'b100
  } ctmc_trx_e;
  typedef enum logic [1:0] {
    WUP_IDLE = 2'b00, WUP_DOM1 = 2'b01, WUP_REC = 2'b10, WUP_DOM2 = 2'b11
  } ctmc_wup_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ctmc_wb_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ctmc_wb_rsp_s;
endpackage

// >>> ctmc_top.sv
`timescale 1ns/1ps
// Contract
// - reset threshold field picks 90, 80, 70 or 60 percent of main output
// - on the 3.3 V variant the threshold field stays 00, i.e. 90 percent
// - aux config: 00 off, 01 Normal, 10 Normal/Standby/Reset, 11 also Sleep
// - bit 6 picks higher (0) or lower (1) pnp current thresholds
// - aux status reads 00 ok, 01 undervolt, 10 overvolt, 11 disabled
// - main status bit reads 1 while main output is below 90 percent
// - in Normal, mode field 01 or 10 requests Active
// - in Normal, mode field 11 gives Listen-only with mid-level bias
// - supply undervolt detection on with mode 01, off with mode 10
// - in Active settings, main below chosen threshold forces Offline family
// - transmit line low at Active request holds Listen-only until it rises
// - Standby/Sleep: bias on bus activity, Offline again after silence timeout
// - Normal with mode 00, 01 with low transceiver supply, or 01/10 with main below threshold, uses Offline family
// - ground bias in Offline, mid-level bias in Offline Bias, Active, Listen
// - chip Off, Overtemp or low battery: Off mode, bus floating, left once the condition clears
// - Offline modes watch for bus wake only with bus wake enabled
// - wake pattern detection only in Offline, wake enabled, selective wake off
// - valid wake sets flag; Standby pulls receive low; Sleep turns main on
// - Active passes data both ways; Listen-only receives and never drives
// - Listen-only while transmit low before Active, or main below 90 percent, even mode 01
// - transceiver status bit shows whether the transceiver is Active
module ctmc_top #(
  parameter int unsigned SILENCE_CYC = ctmc_pkg::SILENCE_CYC,
  parameter int unsigned WAKE_TO_CYC = ctmc_pkg::WAKE_TO_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ctmc_pkg::ctmc_wb_req_s wb_i,
  output ctmc_pkg::ctmc_wb_rsp_s wb_o,
  input wire ctmc_pkg::ctmc_chip_e chip_mode_i,
  input wire logic variant_3v3_i,
  input wire logic [3:0] main_below_i,
  input wire logic aux_uv_i,
  input wire logic aux_ov_i,
  input wire logic trx_supply_uv_i,
  input wire logic bat_uv_i,
  input wire logic tx_i,
  input wire logic bus_dom_i,
  output logic rx_o,
  output logic bus_dom_o,
  output logic [1:0] bias_o,
  output ctmc_pkg::ctmc_trx_e trx_mode_o,
  output logic aux_on_o,
  output logic pnp_low_thr_o,
  output logic main_reset_req_o,
  output logic main_wake_on_o
);
  // aux regulator on/off per chip mode
  function automatic logic aux_on_f(input logic [1:0] cfg, input ctmc_pkg::ctmc_chip_e m);
    logic on;
    on = 1'b0;
    case (cfg)
      ctmc_pkg::AUXC_OFF: on = 1'b0;
      ctmc_pkg::AUXC_NORMAL: on = (m == ctmc_pkg::CHIP_NORMAL);
      ctmc_pkg::AUXC_AWAKE: on = (m == ctmc_pkg::CHIP_NORMAL) ||
        (m == ctmc_pkg::CHIP_STANDBY) || (m == ctmc_pkg::CHIP_RESET);
      default: on = (m == ctmc_pkg::CHIP_NORMAL) || (m == ctmc_pkg::CHIP_STANDBY) ||
        (m == ctmc_pkg::CHIP_RESET) || (m == ctmc_pkg::CHIP_SLEEP);
    endcase
    return on;
  endfunction

  logic [7:0] regc_r;
  logic [7:0] canc_r;
  logic wake_en_r;
  logic wake_flag_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic silence_r;
  logic [19:0] sil_cnt_r;
  logic bus_prev_r;
  logic wake_hit_r;
  logic [12:0] ph_cnt_r;
  logic [19:0] to_cnt_r;
  ctmc_pkg::ctmc_trx_e trx_r;
  ctmc_pkg::ctmc_trx_e trx_nxt;
  ctmc_pkg::ctmc_wup_e wup_r;
  logic [1:0] thr_eff;
  logic [1:0] mode;
  logic [1:0] aux_cfg;
  logic [1:0] aux_stat;
  logic [7:0] idx;
  logic req;
  logic wr_go;
  logic [7:0] rd_mux;
  logic bus_edge;
  logic pn_on;
  logic wake_start;
  logic wake_keep;
  logic rx_nxt;

  // field views
  assign thr_eff = variant_3v3_i ? ctmc_pkg::THR_90 :
    regc_r[ctmc_pkg::REGC_THR_LSB +: 2];
  assign mode = canc_r[ctmc_pkg::CANC_MODE_LSB +: 2];
  assign aux_cfg = regc_r[ctmc_pkg::REGC_AUX_LSB +: 2];
  assign pn_on = canc_r[ctmc_pkg::CANC_SEL_BIT] & canc_r[ctmc_pkg::CANC_CFG_BIT];

  // wishbone decode, one wait state per access
  assign idx = wb_i.adr[9:2];
  assign req = wb_i.cyc & wb_i.stb;
  assign wr_go = req & wb_i.we & ack_r & wb_i.sel[0];
  assign wb_o = '{ack: ack_r, dat: dat_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // aux status code
  always_comb begin
    if (!aux_on_o) begin
      aux_stat = ctmc_pkg::AUX_OFF;
    end else if (aux_uv_i) begin
      aux_stat = ctmc_pkg::AUX_UV;
    end else if (aux_ov_i) begin
      aux_stat = ctmc_pkg::AUX_OV;
    end else begin
      aux_stat = ctmc_pkg::AUX_OK;
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      ctmc_pkg::IDX_REG_CTRL: begin
        rd_mux = regc_r;
        rd_mux[ctmc_pkg::REGC_THR_LSB +: 2] = thr_eff;
      end
      ctmc_pkg::IDX_SUPPLY_STAT: begin
        rd_mux[ctmc_pkg::SUP_AUX_LSB +: 2] = aux_stat;
        rd_mux[ctmc_pkg::SUP_MAIN_BIT] = main_below_i[0];
      end
      ctmc_pkg::IDX_CAN_CTRL: rd_mux = canc_r;
      ctmc_pkg::IDX_TRX_STAT: begin
        rd_mux[ctmc_pkg::TRXS_ACTIVE_BIT] = (trx_r == ctmc_pkg::TRX_ACTIVE);
        rd_mux[ctmc_pkg::TRXS_SILENCE_BIT] = silence_r;
        rd_mux[ctmc_pkg::TRXS_SUPPLY_BIT] = trx_supply_uv_i &
          (mode == ctmc_pkg::MODE_ACT_UV);
      end
      ctmc_pkg::IDX_WAKE_CTRL: rd_mux[ctmc_pkg::WAKE_EN_BIT] = wake_en_r;
      ctmc_pkg::IDX_WAKE_STAT: rd_mux[ctmc_pkg::WAKE_FLAG_BIT] = wake_flag_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data captured as ack rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      dat_r <= {24'h00_0000, rd_mux};
    end
  end

  // regulator control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regc_r <= ctmc_pkg::REGC_RST;
    end else if (wr_go && idx == ctmc_pkg::IDX_REG_CTRL) begin
      regc_r <= 8'h00;
      regc_r[ctmc_pkg::REGC_PNP_BIT] <= wb_i.dat[ctmc_pkg::REGC_PNP_BIT];
      regc_r[ctmc_pkg::REGC_AUX_LSB +: 2] <= wb_i.dat[ctmc_pkg::REGC_AUX_LSB +: 2];
      regc_r[ctmc_pkg::REGC_THR_LSB +: 2] <= variant_3v3_i ? ctmc_pkg::THR_90 :
        wb_i.dat[ctmc_pkg::REGC_THR_LSB +: 2];
    end
  end

  // can control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      canc_r <= ctmc_pkg::CANC_RST;
    end else if (wr_go && idx == ctmc_pkg::IDX_CAN_CTRL) begin
      canc_r <= 8'h00;
      canc_r[ctmc_pkg::CANC_SEL_BIT +: 3] <= wb_i.dat[ctmc_pkg::CANC_SEL_BIT +: 3];
      canc_r[ctmc_pkg::CANC_MODE_LSB +: 2] <= wb_i.dat[ctmc_pkg::CANC_MODE_LSB +: 2];
    end
  end

  // wake enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_en_r <= ctmc_pkg::WAKEC_RST;
    end else if (wr_go && idx == ctmc_pkg::IDX_WAKE_CTRL) begin
      wake_en_r <= wb_i.dat[ctmc_pkg::WAKE_EN_BIT];
    end
  end

  // wake flag, set beats write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_flag_r <= 1'b0;
    end else if (wake_hit_r) begin
      wake_flag_r <= 1'b1;
    end else if (wr_go && idx == ctmc_pkg::IDX_WAKE_STAT &&
                 wb_i.dat[ctmc_pkg::WAKE_FLAG_BIT]) begin
      wake_flag_r <= 1'b0;
    end
  end

  // bus edge and silence timer
  assign bus_edge = bus_dom_i ^ bus_prev_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_prev_r <= 1'b0;
      sil_cnt_r <= 20'h0_0000;
      silence_r <= 1'b1;
    end else begin
      bus_prev_r <= bus_dom_i;
      if (bus_edge) begin
        sil_cnt_r <= 20'h0_0000;
        silence_r <= 1'b0;
      end else if (sil_cnt_r >= 20'(SILENCE_CYC - 1)) begin
        silence_r <= 1'b1;
      end else begin
        sil_cnt_r <= sil_cnt_r + 20'h0_0001;
      end
    end
  end

  // transceiver mode selection
  always_comb begin
    trx_nxt = silence_r ? ctmc_pkg::TRX_OFFLINE : ctmc_pkg::TRX_OFFLINE_BIAS;
    if (chip_mode_i == ctmc_pkg::CHIP_OFF || chip_mode_i == ctmc_pkg::CHIP_OVERTEMP ||
        bat_uv_i) begin
      trx_nxt = ctmc_pkg::TRX_OFF;
    end else if (chip_mode_i == ctmc_pkg::CHIP_NORMAL) begin
      case (mode)
        ctmc_pkg::MODE_OFFLINE: trx_nxt = trx_nxt;
        ctmc_pkg::MODE_LISTEN: trx_nxt = ctmc_pkg::TRX_LISTEN;
        default: begin
          if (main_below_i[thr_eff]) begin
            trx_nxt = trx_nxt;
          end else if (mode == ctmc_pkg::MODE_ACT_UV && trx_supply_uv_i) begin
            trx_nxt = trx_nxt;
          end else if (main_below_i[0] || (trx_r != ctmc_pkg::TRX_ACTIVE && !tx_i)) begin
            trx_nxt = ctmc_pkg::TRX_LISTEN;
          end else begin
            trx_nxt = ctmc_pkg::TRX_ACTIVE;
          end
        end
      endcase
    end
  end

  assign rx_nxt = (trx_nxt == ctmc_pkg::TRX_ACTIVE || trx_nxt == ctmc_pkg::TRX_LISTEN) ?
    ~bus_dom_i : ~(chip_mode_i == ctmc_pkg::CHIP_STANDBY && wake_flag_r);

  // state and registered pin outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trx_r <= ctmc_pkg::TRX_OFF;
      bias_o <= ctmc_pkg::BIAS_FLOAT;
      bus_dom_o <= 1'b0;
      rx_o <= 1'b1;
    end else begin
      trx_r <= trx_nxt;
      case (trx_nxt)
        ctmc_pkg::TRX_OFF: bias_o <= ctmc_pkg::BIAS_FLOAT;
        ctmc_pkg::TRX_OFFLINE: bias_o <= ctmc_pkg::BIAS_GND;
        default: bias_o <= ctmc_pkg::BIAS_MID;
      endcase
      bus_dom_o <= (trx_nxt == ctmc_pkg::TRX_ACTIVE) & ~tx_i;
      rx_o <= rx_nxt;
    end
  end
  assign trx_mode_o = trx_r;

  // regulator side outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_on_o <= 1'b0;
      pnp_low_thr_o <= 1'b0;
      main_reset_req_o <= 1'b0;
      main_wake_on_o <= 1'b0;
    end else begin
      aux_on_o <= aux_on_f(aux_cfg, chip_mode_i);
      pnp_low_thr_o <= regc_r[ctmc_pkg::REGC_PNP_BIT];
      main_reset_req_o <= main_below_i[thr_eff];
      main_wake_on_o <= wake_hit_r & (chip_mode_i == ctmc_pkg::CHIP_SLEEP);
    end
  end

  // wake pattern detector
  assign wake_start = (trx_r == ctmc_pkg::TRX_OFFLINE) & wake_en_r & ~pn_on;
  assign wake_keep = wake_en_r & ~pn_on & (trx_r == ctmc_pkg::TRX_OFFLINE ||
    trx_r == ctmc_pkg::TRX_OFFLINE_BIAS);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wup_r <= ctmc_pkg::WUP_IDLE;
      ph_cnt_r <= 13'h0000;
      to_cnt_r <= 20'h0_0000;
      wake_hit_r <= 1'b0;
    end else begin
      wake_hit_r <= 1'b0;
      ph_cnt_r <= ph_cnt_r + 13'h0001;
      to_cnt_r <= to_cnt_r + 20'h0_0001;
      if (!wake_keep || (wup_r != ctmc_pkg::WUP_IDLE &&
          to_cnt_r >= 20'(WAKE_TO_CYC))) begin
        wup_r <= ctmc_pkg::WUP_IDLE;
      end else begin
        case (wup_r)
          ctmc_pkg::WUP_IDLE: begin
            ph_cnt_r <= 13'h0001;
            to_cnt_r <= 20'h0_0001;
            if (bus_dom_i && wake_start) begin
              wup_r <= ctmc_pkg::WUP_DOM1;
            end
          end
          ctmc_pkg::WUP_DOM1: begin
            if (!bus_dom_i) begin
              ph_cnt_r <= 13'h0001;
              wup_r <= (ph_cnt_r >= 13'(ctmc_pkg::WAKE_DOM_CYC)) ?
                ctmc_pkg::WUP_REC : ctmc_pkg::WUP_IDLE;
            end
          end
          ctmc_pkg::WUP_REC: begin
            if (bus_dom_i) begin
              ph_cnt_r <= 13'h0001;
              if (ph_cnt_r >= 13'(ctmc_pkg::WAKE_REC_CYC)) begin
                wup_r <= ctmc_pkg::WUP_DOM2;
              end else begin
                wup_r <= ctmc_pkg::WUP_DOM1;
                to_cnt_r <= 20'h0_0001;
              end
            end
          end
          ctmc_pkg::WUP_DOM2: begin
            if (!bus_dom_i) begin
              wup_r <= ctmc_pkg::WUP_IDLE;
            end else if (ph_cnt_r >= 13'(ctmc_pkg::WAKE_DOM_CYC - 1)) begin
              wake_hit_r <= 1'b1;
              wup_r <= ctmc_pkg::WUP_IDLE;
            end
          end
          default: wup_r <= ctmc_pkg::WUP_IDLE;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  thr_fixed_a: assert property (variant_3v3_i ##1 variant_3v3_i |->
    main_reset_req_o == $past(main_below_i[0]))
    else $error("threshold not fixed on 3.3 V variant");
  aux_off_a: assert property (aux_cfg == ctmc_pkg::AUXC_OFF |=> !aux_on_o)
    else $error("aux on while configured off");
  aux_stat_a: assert property (!aux_on_o |-> aux_stat == ctmc_pkg::AUX_OFF)
    else $error("aux status not disabled");
  listen_a: assert property ((chip_mode_i == ctmc_pkg::CHIP_NORMAL &&
    mode == ctmc_pkg::MODE_LISTEN && !bat_uv_i) |=> trx_r == ctmc_pkg::TRX_LISTEN)
    else $error("listen-only not entered");
  tx_low_a: assert property ((trx_r != ctmc_pkg::TRX_ACTIVE && !tx_i) |=>
    trx_r != ctmc_pkg::TRX_ACTIVE)
    else $error("active entered with transmit low");
  bias_on_a: assert property ((chip_mode_i == ctmc_pkg::CHIP_STANDBY && bus_edge) ##1
    (chip_mode_i == ctmc_pkg::CHIP_STANDBY && !bat_uv_i) |=>
    trx_r == ctmc_pkg::TRX_OFFLINE_BIAS && bias_o == ctmc_pkg::BIAS_MID)
    else $error("bus activity did not bias");
  gnd_bias_a: assert property (trx_r == ctmc_pkg::TRX_OFFLINE |->
    bias_o == ctmc_pkg::BIAS_GND)
    else $error("offline bias wrong");
  off_mode_a: assert property (bat_uv_i |=> trx_r == ctmc_pkg::TRX_OFF &&
    bias_o == ctmc_pkg::BIAS_FLOAT && !bus_dom_o)
    else $error("off mode not entered");
  wake_arm_a: assert property ((wup_r == ctmc_pkg::WUP_DOM1 &&
    $past(wup_r) == ctmc_pkg::WUP_IDLE) |-> $past(wake_start))
    else $error("wake detection armed outside offline");
  wake_flag_a: assert property (wake_hit_r |=> wake_flag_r [*2])
    else $error("wake flag not held");
  no_drive_a: assert property (trx_r != ctmc_pkg::TRX_ACTIVE |-> !bus_dom_o)
    else $error("bus driven outside active");
  silence_a: assert property (bus_edge |=> !silence_r && sil_cnt_r == 20'h0_0000)
    else $error("silence timer not restarted");

  active_c: cover property (trx_r == ctmc_pkg::TRX_LISTEN ##1 trx_r == ctmc_pkg::TRX_ACTIVE);
  bias_c: cover property (trx_r == ctmc_pkg::TRX_OFFLINE ##1 trx_r == ctmc_pkg::TRX_OFFLINE_BIAS);
  wake_c: cover property (wake_hit_r);
  sleep_wake_c: cover property (main_wake_on_o);
endmodule // ctmc_top
